// [design/vsid_pkg.sv]
// Contract
// - Claim only addresses at or above base and below bound.
// - Bound of zero means no upper limit above base.
// - Destination address is source address plus translation offset.
// - Offset is two's complement; negative values shift the address down.
// - Image four fields use bits 31:12, 4 Kbyte granularity.
// - Image five fields use bits 31:16; base is lowest decoded address.
// - Image enable gates decoding; cleared by power-up and VME reset.
// - Posted-write bit lets writes be posted; resets to zero.
// - Prefetch bit lets reads be prefetched; resets to zero.
// - Posted and prefetch bits ignored unless PCI space is memory.
// - Only memory-space transactions are decoupled; others complete directly.
// - Program/data qualifier: 01 data, 10 program, 11 both; reset 11.
// - Privilege qualifier: 01 user, 10 supervisor, 11 both; reset 11.
// - Image five space: 001 A24, 010 A32, 110 User1, 111 User2.
// - Wide bit allows 64-bit PCI transactions; resets to zero.
// - Lock bit locks PCI bus during a VME read-modify-write.
// - PCI space: 00 memory, 01 I/O, 10 configuration; reset 00.
// - No image responds unless bus-master allow bit is set.
// - Image four additionally decodes space code 000 as A16.
package vsid_pkg;
   // =======================================
   // Register map (byte addresses)
   localparam logic [11:0] OFS_CMD_STATUS = 12'h0004;
   localparam logic [11:0] OFS_DEC_STATUS = 12'h0008;
   localparam logic [11:0] OFS_IMG4_CTL = 12'h0f90;
   localparam logic [11:0] OFS_IMG4_BASE = 12'h0f94;
   localparam logic [11:0] OFS_IMG4_BOUND = 12'h0f98;
   localparam logic [11:0] OFS_IMG4_OFFSET = 12'h0f9c;
   localparam logic [11:0] OFS_IMG5_CTL = 12'h0fa4;
   localparam logic [11:0] OFS_IMG5_BASE = 12'h0fa8;
   localparam logic [11:0] OFS_IMG5_BOUND = 12'h0fac;
   localparam logic [11:0] OFS_IMG5_OFFSET = 12'h0fb0;
   // =======================================
   // Field layout
   localparam int BIT_EN = 31;
   localparam int BIT_POST = 30;
   localparam int BIT_PREF = 29;
   localparam int POS_PROG = 22;
   localparam int POS_SUPER = 20;
   localparam int POS_SPACE = 16;
   localparam int BIT_WIDE = 7;
   localparam int BIT_LOCK = 6;
   localparam int POS_PSPACE = 0;
   localparam int BIT_MASTER = 2;
   localparam logic [31:0] CTL_MASK = 32'he0f7_00c3;
   localparam logic [31:0] IMG4_ADDR_MASK = 32'hffff_f000;
   localparam logic [31:0] IMG5_ADDR_MASK = 32'hffff_0000;
   localparam logic [31:0] CMD_MASK = 32'h0000_0004;
   // =======================================
   // Reset values
   localparam logic [31:0] CTL_RESET = 32'h00f0_0000;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [31:0] CMD_RESET = 32'h0000_0000;
   // =======================================
   // Encodings
   localparam logic [2:0] VSP_A16 = 3'h0;
   localparam logic [2:0] VSP_A24 = 3'h1;
   localparam logic [2:0] VSP_A32 = 3'h2;
   localparam logic [2:0] VSP_USER1 = 3'h6;
   localparam logic [2:0] VSP_USER2 = 3'h7;
   localparam logic [1:0] PSP_MEM = 2'h0;
   localparam logic [1:0] PSP_IO = 2'h1;
   localparam logic [1:0] PSP_CFG = 2'h2;
   localparam logic [3:0] PCI_MEM_RD = 4'h6;
   localparam logic [3:0] PCI_IO_RD = 4'h2;
   localparam logic [3:0] PCI_CFG_RD = 4'ha;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [5:0] am;
      logic write;
      logic rmw;
   } vsid_cycle_t;

   typedef struct packed {
      logic valid;
      logic hit;
      logic image;
      logic [31:0] pci_addr;
      logic [3:0] pci_cmd;
      logic posted;
      logic prefetch;
      logic wide;
      logic lock;
   } vsid_claim_t;
endpackage : vsid_pkg

// [design/vsid_decoder.sv]
`timescale 1ns/1ps
module vsid_decoder
   import vsid_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic vme_sysreset,
   input wire vsid_cycle_t vme_cycle,
   output vsid_claim_t claim
);
   // =======================================
   // Register storage
   logic [31:0] cmd_status;
   logic [31:0] image4_control, image4_base, image4_bound, image4_offset;
   logic [31:0] image5_control, image5_base, image5_bound, image5_offset;
   logic [31:0] dec_status;
   logic wr_pend, rd_pend;
   logic [11:0] ph_addr;

   // Address-modifier match against one image's control word
   function automatic logic am_match(input logic [31:0] ctl, input logic [5:0] am,
                                     input logic allow_a16);
      logic [2:0] vsp;
      logic [1:0] prog, sup;
      logic sp, pg, pr;
      vsp = ctl[POS_SPACE +: 3];
      prog = ctl[POS_PROG +: 2];
      sup = ctl[POS_SUPER +: 2];
      sp = 1'b0;
      case (vsp)
         VSP_A16: sp = allow_a16 && am[5:3] == 3'h5 && am[1:0] == 2'h1;
         VSP_A24: sp = am[5:3] == 3'h7;
         VSP_A32: sp = am[5:3] == 3'h1;
         VSP_USER1: sp = am[5:3] == 3'h2;
         VSP_USER2: sp = am[5:3] == 3'h3;
         default: sp = 1'b0;
      endcase
      // User-defined codes carry no program or privilege meaning
      if (vsp == VSP_USER1 || vsp == VSP_USER2) begin
         pg = 1'b1;
         pr = 1'b1;
      end else begin
         pg = (am[1:0] == 2'h2) ? prog[1] : prog[0];
         pr = am[2] ? sup[1] : sup[0];
      end
      return sp && pg && pr;
   endfunction : am_match

   // Window and enable check; mask keeps only implemented bits
   function automatic logic in_window(input logic [31:0] ctl, input logic [31:0] base,
                                      input logic [31:0] bound, input logic [31:0] mask,
                                      input logic [31:0] addr);
      logic [31:0] a;
      logic above, below;
      a = addr & mask;
      above = a >= base;
      below = (bound == 32'h0000_0000) || (a < bound);
      return ctl[BIT_EN] && ctl[POS_PSPACE +: 2] != 2'h3 && above && below;
   endfunction : in_window

   // =======================================
   // AHB-Lite slave
   wire addr_ok = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         ph_addr <= 12'h000;
      end else begin
         if (hready) begin
            wr_pend <= addr_ok && hwrite;
            rd_pend <= addr_ok && !hwrite;
            ph_addr <= haddr[11:0];
         end else begin
            rd_pend <= 1'b0;
         end
      end
   end

   // Reads take one wait state so a write in the previous beat is seen
   assign hreadyout = !rd_pend;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_pend) begin
         if (ph_addr == OFS_CMD_STATUS) begin
            hrdata <= cmd_status;
         end else if (ph_addr == OFS_DEC_STATUS) begin
            hrdata <= dec_status;
         end else if (ph_addr == OFS_IMG4_CTL) begin
            hrdata <= image4_control;
         end else if (ph_addr == OFS_IMG4_BASE) begin
            hrdata <= image4_base;
         end else if (ph_addr == OFS_IMG4_BOUND) begin
            hrdata <= image4_bound;
         end else if (ph_addr == OFS_IMG4_OFFSET) begin
            hrdata <= image4_offset;
         end else if (ph_addr == OFS_IMG5_CTL) begin
            hrdata <= image5_control;
         end else if (ph_addr == OFS_IMG5_BASE) begin
            hrdata <= image5_base;
         end else if (ph_addr == OFS_IMG5_BOUND) begin
            hrdata <= image5_bound;
         end else if (ph_addr == OFS_IMG5_OFFSET) begin
            hrdata <= image5_offset;
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // =======================================
   // Image registers; VME reset clears them like power-up
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         image4_control <= CTL_RESET;
         image4_base <= ADDR_RESET;
         image4_bound <= ADDR_RESET;
         image4_offset <= ADDR_RESET;
      end else if (vme_sysreset) begin
         image4_control <= CTL_RESET;
         image4_base <= ADDR_RESET;
         image4_bound <= ADDR_RESET;
         image4_offset <= ADDR_RESET;
      end else if (wr_pend) begin
         if (ph_addr == OFS_IMG4_CTL) begin
            image4_control <= hwdata & CTL_MASK;
         end else if (ph_addr == OFS_IMG4_BASE) begin
            image4_base <= hwdata & IMG4_ADDR_MASK;
         end else if (ph_addr == OFS_IMG4_BOUND) begin
            image4_bound <= hwdata & IMG4_ADDR_MASK;
         end else if (ph_addr == OFS_IMG4_OFFSET) begin
            image4_offset <= hwdata & IMG4_ADDR_MASK;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         image5_control <= CTL_RESET;
         image5_base <= ADDR_RESET;
         image5_bound <= ADDR_RESET;
         image5_offset <= ADDR_RESET;
      end else if (vme_sysreset) begin
         image5_control <= CTL_RESET;
         image5_base <= ADDR_RESET;
         image5_bound <= ADDR_RESET;
         image5_offset <= ADDR_RESET;
      end else if (wr_pend) begin
         if (ph_addr == OFS_IMG5_CTL) begin
            image5_control <= hwdata & CTL_MASK;
         end else if (ph_addr == OFS_IMG5_BASE) begin
            image5_base <= hwdata & IMG5_ADDR_MASK;
         end else if (ph_addr == OFS_IMG5_BOUND) begin
            image5_bound <= hwdata & IMG5_ADDR_MASK;
         end else if (ph_addr == OFS_IMG5_OFFSET) begin
            image5_offset <= hwdata & IMG5_ADDR_MASK;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_status <= CMD_RESET;
      end else if (wr_pend && ph_addr == OFS_CMD_STATUS) begin
         cmd_status <= hwdata & CMD_MASK;
      end
   end

   // =======================================
   // Decode and translation
   logic hit4, hit5, sel5;
   logic [31:0] ctl_sel, off_sel, mask_sel;
   logic [1:0] psp_sel;
   logic is_mem;

   always_comb begin
      hit4 = in_window(image4_control, image4_base, image4_bound, IMG4_ADDR_MASK,
                       vme_cycle.addr) && am_match(image4_control, vme_cycle.am, 1'b1);
      hit5 = in_window(image5_control, image5_base, image5_bound, IMG5_ADDR_MASK,
                       vme_cycle.addr) && am_match(image5_control, vme_cycle.am, 1'b0);
      // Overlapping windows resolve to image four
      sel5 = !hit4;
      ctl_sel = sel5 ? image5_control : image4_control;
      off_sel = sel5 ? image5_offset : image4_offset;
      mask_sel = sel5 ? IMG5_ADDR_MASK : IMG4_ADDR_MASK;
      psp_sel = ctl_sel[POS_PSPACE +: 2];
      is_mem = psp_sel == PSP_MEM;
   end

   wire master_on = cmd_status[BIT_MASTER];
   wire any_hit = master_on && (hit4 || hit5);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         claim <= '0;
      end else begin
         claim.valid <= vme_cycle.valid;
         claim.hit <= vme_cycle.valid && any_hit;
         claim.image <= sel5;
         // Offset adds modulo 2^32, so a two's complement value moves down
         claim.pci_addr <= ((vme_cycle.addr & mask_sel) + off_sel)
                           | (vme_cycle.addr & ~mask_sel);
         case (psp_sel)
            PSP_IO: claim.pci_cmd <= PCI_IO_RD | {3'h0, vme_cycle.write};
            PSP_CFG: claim.pci_cmd <= PCI_CFG_RD | {3'h0, vme_cycle.write};
            default: claim.pci_cmd <= PCI_MEM_RD | {3'h0, vme_cycle.write};
         endcase
         // Non-memory cycles complete coupled whatever the enables say
         claim.posted <= is_mem && ctl_sel[BIT_POST] && vme_cycle.write;
         claim.prefetch <= is_mem && ctl_sel[BIT_PREF] && !vme_cycle.write;
         claim.wide <= ctl_sel[BIT_WIDE];
         claim.lock <= any_hit && ctl_sel[BIT_LOCK] && vme_cycle.rmw;
      end
   end

   // Last offered VME cycle, hit or miss, visible to software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dec_status <= 32'h0000_0000;
      end else if (vme_cycle.valid) begin
         dec_status <= {any_hit, sel5, 30'h0000_0000};
      end
   end

   // =======================================
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_cycle4;
      vme_cycle.valid && hit4 && master_on;
   endsequence

   a_claim_needs_master: assert property (claim.hit |-> $past(master_on))
      else $error("claim without bus-master allow");
   a_window_lower: assert property (claim.hit && !claim.image |->
      ($past(vme_cycle.addr) & IMG4_ADDR_MASK) >= $past(image4_base))
      else $error("image four claim below base");
   a_window_upper: assert property (claim.hit && !claim.image && $past(image4_bound) != 0
      |-> ($past(vme_cycle.addr) & IMG4_ADDR_MASK) < $past(image4_bound))
      else $error("image four claim at or above bound");
   a_trans_four: assert property (s_cycle4 |=> claim.hit && !claim.image &&
      claim.pci_addr[31:12] == $past(vme_cycle.addr[31:12] + image4_offset[31:12]) &&
      claim.pci_addr[11:0] == $past(vme_cycle.addr[11:0]))
      else $error("image four translation wrong");
   a_trans_five: assert property (claim.hit && claim.image |->
      claim.pci_addr[31:16] == $past(vme_cycle.addr[31:16] + image5_offset[31:16]) &&
      claim.pci_addr[15:0] == $past(vme_cycle.addr[15:0]))
      else $error("image five translation wrong");
   a_posted_mem_only: assert property ((claim.posted || claim.prefetch) |->
      claim.pci_cmd[3:1] == PCI_MEM_RD[3:1])
      else $error("decoupled cycle outside memory space");
   a_vme_reset_clear: assert property (vme_sysreset |=>
      !image4_control[BIT_EN] && !image5_control[BIT_EN] &&
      image4_control[POS_PROG +: 2] == 2'h3 && image5_control[POS_SUPER +: 2] == 2'h3)
      else $error("VME reset left image state");
   a_disabled_no_hit: assert property (vme_cycle.valid && !image4_control[BIT_EN] &&
      !image5_control[BIT_EN] |=> !claim.hit)
      else $error("disabled image claimed");
   a_lock_rmw_only: assert property (claim.lock |-> claim.hit && $past(vme_cycle.rmw))
      else $error("lock without read-modify-write");
   a_read_wait: assert property (hready && hsel && htrans[1] && !hwrite |=>
      !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
endmodule : vsid_decoder

// [dv/vsid_vme_master.sv]
`timescale 1ns/1ps
// =======================================
// VME master model: one cycle offered per call
module vsid_vme_master
   import vsid_pkg::*;
(
   input wire logic hclk,
   output vsid_cycle_t vme_cycle
);
   initial vme_cycle = '0;

   // Idle lines show the inverse of the last offer, so stale values never pass for fresh ones
   task automatic send(input logic [31:0] a, input logic [5:0] am, input logic w,
                       input logic rmw);
      vsid_cycle_t c;
      vsid_cycle_t idle;
      c = '{valid: 1'b1, addr: a, am: am, write: w, rmw: rmw};
      idle = ~c;
      idle.valid = 1'b0;
      @(posedge hclk);
      vme_cycle <= c;
      @(posedge hclk);
      vme_cycle <= idle;
   endtask : send
endmodule : vsid_vme_master

// [dv/vme_slave_image_decoder_tb.sv]
`timescale 1ns/1ps
module vme_slave_image_decoder_tb
   import vsid_pkg::*;
   ;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hready, hreadyout, hresp, vme_sysreset;
   logic [31:0] haddr, hwdata, hrdata, b, c;
   logic [1:0] htrans;
   logic [2:0] hsize;
   vsid_cycle_t vme_cycle;
   vsid_claim_t claim;
   logic [31:0] mreg [logic [11:0]];
   int n_fail = 0;
   int checks = 0;
   int k, r;
   localparam logic [11:0] REGS [10] = '{OFS_CMD_STATUS, OFS_IMG4_CTL, OFS_IMG4_BASE,
      OFS_IMG4_BOUND, OFS_IMG4_OFFSET, OFS_IMG5_CTL, OFS_IMG5_BASE, OFS_IMG5_BOUND,
      OFS_IMG5_OFFSET, 12'h0fa0};
   localparam logic [2:0] VSP_T [5] = '{VSP_A16, VSP_A24, VSP_A32, VSP_USER1, VSP_USER2};
   localparam logic [2:0] AMS_T [5] = '{3'h5, 3'h7, 3'h1, 3'h2, 3'h3};

   always #12.5 hclk = ~hclk;
   assign hready = hreadyout;

   vsid_decoder DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .vme_sysreset(vme_sysreset),
      .vme_cycle(vme_cycle), .claim(claim));
   vsid_vme_master u_vme (.hclk(hclk), .vme_cycle(vme_cycle));

   // =======================================
   // Checking and bus tasks
   task automatic close_out();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   function automatic logic [31:0] msk(input logic [11:0] a);
      case (a)
         OFS_CMD_STATUS: return CMD_MASK;
         OFS_IMG4_CTL, OFS_IMG5_CTL: return CTL_MASK;
         OFS_IMG4_BASE, OFS_IMG4_BOUND, OFS_IMG4_OFFSET: return IMG4_ADDR_MASK;
         OFS_IMG5_BASE, OFS_IMG5_BOUND, OFS_IMG5_OFFSET: return IMG5_ADDR_MASK;
         default: return 32'h0000_0000;
      endcase
   endfunction : msk

   task automatic rst_img(input logic all);
      foreach (REGS[j]) if (all || REGS[j] != OFS_CMD_STATUS)
         mreg[REGS[j]] = (msk(REGS[j]) == CTL_MASK) ? CTL_RESET : ADDR_RESET;
   endtask : rst_img

   // Address phase held until hready, then data phase held until hready again
   task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rdat);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rdat = hrdata;
   endtask : ahb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rdat;
      ahb(1'b1, a, d, rdat);
      mreg[a] = d & msk(a);
   endtask : wr

   task automatic rd(input logic [11:0] a);
      logic [31:0] rdat;
      ahb(1'b0, a, 32'h0000_0000, rdat);
      chk("register", rdat, mreg[a]);
   endtask : rd

   // =======================================
   // Reference decode of one image
   function automatic logic hit_of(input int i, input logic [31:0] a, input logic [5:0] am);
      logic [31:0] cc, m, bs, bd;
      logic ok;
      cc = mreg[REGS[1 + 4 * i]];
      bs = mreg[REGS[2 + 4 * i]];
      bd = mreg[REGS[3 + 4 * i]];
      m = i ? IMG5_ADDR_MASK : IMG4_ADDR_MASK;
      case (am[5:3])
         3'h5: ok = am[1:0] == 2'b01 && cc[18:16] == VSP_A16 && i == 0;
         3'h7: ok = cc[18:16] == VSP_A24;
         3'h1: ok = cc[18:16] == VSP_A32;
         3'h2: ok = cc[18:16] == VSP_USER1;
         3'h3: ok = cc[18:16] == VSP_USER2;
         default: ok = 1'b0;
      endcase
      if (am[5:3] inside {3'h5, 3'h7, 3'h1})
         ok = ok && cc[POS_PROG + (am[1:0] == 2'b10)] && cc[POS_SUPER + am[2]];
      return mreg[OFS_CMD_STATUS][BIT_MASTER] && cc[BIT_EN] && cc[1:0] != 2'b11 && ok
         && (a & m) >= bs && (bd == 0 || (a & m) < bd);
   endfunction : hit_of

   task automatic vme(input logic [31:0] a, input logic [5:0] am, input logic w,
                      input logic rmw);
      logic h4, h5;
      int i;
      logic [31:0] cc;
      logic [1:0] s;
      logic [3:0] cmd;
      h4 = hit_of(0, a, am);
      h5 = hit_of(1, a, am);
      i = h4 ? 0 : 1;
      cc = mreg[REGS[1 + 4 * i]];
      s = cc[1:0];
      cmd = (s == PSP_MEM ? PCI_MEM_RD : s == PSP_IO ? PCI_IO_RD : PCI_CFG_RD) | w;
      u_vme.send(a, am, w, rmw);
      mreg[OFS_DEC_STATUS] = {h4 | h5, i[0], 30'h0000_0000};
      @(negedge hclk);
      chk("hit", {claim.valid, claim.hit}, {1'b1, h4 | h5});
      if (h4 | h5)
         chk("claim", {claim.image, claim.pci_addr, claim.pci_cmd, claim.posted,
            claim.prefetch, claim.wide, claim.lock}, {i[0], a + mreg[REGS[4 + 4 * i]], cmd,
            s == PSP_MEM && cc[BIT_POST] && w, s == PSP_MEM && cc[BIT_PREF] && !w,
            cc[BIT_WIDE], cc[BIT_LOCK] && rmw});
   endtask : vme

   // =======================================
   // Main sequence
   initial begin
      #(25 * 20000);
      n_fail++;
      close_out();
   end

   initial begin
      {hresetn, hsel, hwrite, vme_sysreset, haddr, hwdata, htrans, hsize} = '0;
      void'($urandom(3));
      rst_img(1'b1);
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (REGS[j]) rd(REGS[j]);
      foreach (REGS[j]) begin
         wr(REGS[j], 32'hffff_ffff);
         rd(REGS[j]);
      end
      wr(OFS_CMD_STATUS, 32'h0000_0000);
      wr(OFS_IMG4_CTL, 32'h80f2_0000);
      wr(OFS_IMG4_BASE, 32'h1000_3000);
      wr(OFS_IMG4_BOUND, 32'h1000_5000);
      wr(OFS_IMG4_OFFSET, 32'hf000_0000);
      vme(32'h1000_3abc, 6'h0d, 1'b1, 1'b0);
      wr(OFS_CMD_STATUS, 32'h0000_0004);
      foreach (AMS_T[j]) vme(32'h1000_3000 + j * 32'h0000_07ff, 6'h0d, 1'b0, 1'b0);
      vme(32'h1000_2fff, 6'h0d, 1'b0, 1'b0);
      vme(32'h1000_5000, 6'h0d, 1'b0, 1'b0);
      wr(OFS_IMG4_BOUND, 32'h0000_0000);
      vme(32'hffff_fffc, 6'h09, 1'b1, 1'b0);
      for (int s = 0; s < 4; s++) begin
         wr(OFS_IMG4_CTL, 32'he0f2_00c0 | s);
         vme(32'h2000_0010, 6'h0d, 1'b1, 1'b1);
         vme(32'h2000_0014, 6'h0d, 1'b0, 1'b0);
      end
      @(posedge hclk);
      vme_sysreset <= 1'b1;
      @(posedge hclk);
      vme_sysreset <= 1'b0;
      rst_img(1'b0);
      vme(32'h2000_0010, 6'h0d, 1'b1, 1'b0);
      foreach (REGS[j]) rd(REGS[j]);
      // Random windows share one base so both images overlap and image four must win
      repeat (24) begin
         b = $urandom;
         k = $urandom % 5;
         for (int i = 0; i < 2; i++) begin
            c = $urandom | 32'h8000_0000;
            if ($urandom % 4) c = {c[31:19], VSP_T[k], c[15:0]};
            wr(REGS[1 + 4 * i], c);
            wr(REGS[2 + 4 * i], b);
            wr(REGS[3 + 4 * i], ($urandom % 4) ? b + ($urandom & 32'h000f_ffff) : 0);
            wr(REGS[4 + 4 * i], $urandom);
         end
         repeat (16) begin
            r = $urandom;
            vme(b + ($urandom & 32'h0007_ffff) - 32'h0001_0000,
               (r % 4) ? {AMS_T[k], r[4:2]} : r[7:2], r[8], r[9]);
         end
         rd(OFS_DEC_STATUS);
      end
      close_out();
   end
endmodule : vme_slave_image_decoder_tb
